// ==== common/tsi_pkg.sv ====
// Shared constants, encodings and carrier types of the time-slot switch core.
// Assumes one system clock at 40 MHz, where one cycle is half a master clock.
package tsi_pkg;

  // ---------------------------------------------------------------------
  // Lane and frame geometry
  // ---------------------------------------------------------------------
  localparam int LANES_DEF      = 64;   // Serial lanes each way
  localparam int CHANNELS_DEF   = 256;  // Channels per frame at top rate
  localparam int BASE_CHANNELS  = 32;   // Channels per frame at lowest rate
  localparam int BYTE_BITS      = 8;    // Bits per channel

  // ---------------------------------------------------------------------
  // Timing, in system clock cycles
  // ---------------------------------------------------------------------
  localparam int CLKS_PER_MCLK  = 2;    // One master clock = two cycles
  localparam int BIT_CLKS_FAST  = 1 * CLKS_PER_MCLK; // One mclk per bit
  localparam int BIT_CLKS_SLOW  = 2 * CLKS_PER_MCLK; // Two mclk per bit
  localparam int MAX_OFF_HALVES = 15;   // +7.5 master clocks in halves
  localparam int IN_DELAY_CLKS  = MAX_OFF_HALVES + 1; // Input pipeline
  localparam int FP_IDLE_CLKS   = 8;    // Stable span that marks idle level

  // ---------------------------------------------------------------------
  // Reset values and host address map
  // ---------------------------------------------------------------------
  localparam logic       FP_IDLE_RESET = 1'b1;   // Assume low-going pulses
  localparam logic [1:0] ADDR_SEL_DM   = 2'b11;  // Data memory window
  localparam logic [1:0] ADDR_SEL_CM   = 2'b10;  // Connection memory window

  // Lane rate choice; the frame holds BASE_CHANNELS << rate channels
  typedef enum logic [1:0] {
    RATE_2M,
    RATE_4M,
    RATE_8M,
    RATE_16M
  } rate_t;

  // Per-channel mode field, codes fixed by the hardware
  typedef enum logic [1:0] {
    MODE_VAR   = 2'b00,
    MODE_CONST = 2'b01,
    MODE_PROC  = 2'b10,
    MODE_OFF   = 2'b11
  } mode_t;

  // Connection memory entry; src_chan doubles as processor data
  typedef struct packed {
    mode_t      mode;
    logic [5:0] src_lane;
    logic [7:0] src_chan;
  } cm_entry_t;

  // Host access request, as seen on the RAM-like port
  typedef struct packed {
    logic        cs_n;   // Chip select, low active
    logic        ds_n;   // Data strobe, low active
    logic        rw;     // 1 read, 0 write
    logic [15:0] addr;
    logic [15:0] wdata;
  } host_req_t;

  // Bit, channel and bank position within a frame
  typedef struct packed {
    logic [1:0] phase;
    logic [2:0] bitn;
    logic [7:0] ch;
    logic       bank;
  } ctr_t;

endpackage : tsi_pkg

// ==== hdl/tdm_time_slot_switch_core.sv ====
// Time-slot interchange core: 64 lanes in, data memory, connection memory,
// 64 lanes out. Pins are synchronous to clk; the host holds its request
// until ack or read data appears, and takes read data with data_take.
`timescale 1ns/10ps

// Operation
// - All input lanes run at one rate chosen among four by rate select.
// - Output lanes run at the same rate as the input lanes.
// - Top rate carries 256 eight-bit channels per lane per frame.
// - The direction input decides whether a host access reads or writes.
// - Upper pins are lanes 32-63 when all lanes chosen, else enable view.
// - Wide select high uses wide pulse; low auto-detects narrow pulse.
// - Each input lane may lag the frame by half-clock steps up to 7.5.
// - Each input channel is made parallel and stored in data memory.
// - Frame pulse marks the boundary; write address steps channels from it.
// - Switched channels take source lane and channel from their entry.
// - One entry per output channel; many may name one source.
// - Processor mode sends the entry's low byte every frame.
// - Top two entry bits choose processor, constant, variable or off.
// - Mode 1-1 floats only that channel's eight bits on its lane.
// - Drive input low and standby low floats all lanes.
// - Mode 0-0 is variable delay, 0-1 is constant delay.
// - Drive input high enables all lanes but per-channel disabled ones.
// - Drive input low: standby high enables, standby low disables all.
module tdm_time_slot_switch_core
  import tsi_pkg::*;
#(
  parameter int LANES    = LANES_DEF,     // Lanes each way, even
  parameter int CHANNELS = CHANNELS_DEF   // Channels per lane at top rate
) (
  input  wire logic                  clk,                  // 40 MHz clock
  input  wire logic                  reset,                // Sync, high
  input  wire logic [LANES-1:0]      serial_in_lanes,      // Serial inputs
  input  wire logic                  frame_sync_pulse,     // Frame pulse
  input  wire logic                  wide_frame_select,    // Wide pulse mode
  input  wire logic                  master_output_drive,  // Master enable
  input  wire logic                  output_standby,       // Standby enable
  input  wire logic                  all_lanes_select,     // 64 output lanes
  input  wire rate_t                 data_rate_select,     // Lane bit rate
  input  wire logic [LANES-1:0][3:0] lane_offset,          // Half-mclk lag
  input  wire host_req_t             host_req,             // Host request
  input  wire logic                  data_take,            // Host took word
  output logic [15:0]                data_out,             // Read data
  output logic                       data_oe,              // Drives data
  output logic                       ack,                  // Write done
  output logic [LANES/2-1:0]         serial_out_lanes_low,    // Lanes 0-31
  output logic [LANES/2-1:0]         serial_out_lanes_low_oe, // Their enable
  output logic [LANES/2-1:0]         serial_out_lanes_high_or_enable_view,
  output logic [LANES/2-1:0]         serial_out_lanes_high_oe // Upper enable
);

  // -----------------------------------------------------------------------
  // State
  // -----------------------------------------------------------------------
  localparam int HALF = LANES / 2;

  typedef struct packed {
    logic [1:0][LANES-1:0][CHANNELS-1:0][7:0] dm;   // Two frame banks
    cm_entry_t [LANES-1:0][CHANNELS-1:0]       cm;   // Connection memory
    logic [LANES-1:0][15:0]                    hist; // Input history
    logic [LANES-1:0][6:0]                     in_sr;
    logic [LANES-1:0][7:0]                     out_sr;
    logic [LANES-1:0]                          out_bit;
    logic [LANES-1:0]                          chan_en;
    ctr_t                                      octr;
    ctr_t                                      ictr;
    logic [IN_DELAY_CLKS-1:0]                  bdly;
    logic                                      fp_prev;
    logic                                      idle_lvl;
    logic [3:0]                                stable;
    logic                                      busy;
    logic                                      ack;
    logic                                      head_v;
    logic [15:0]                               head_d;
    logic                                      skid_v;
    logic [15:0]                               skid_d;
    logic [HALF-1:0]                           low_q;
    logic [HALF-1:0]                           low_oe;
    logic [HALF-1:0]                           high_q;
    logic [HALF-1:0]                           high_oe;
  } state_t;

  state_t s_q;
  state_t s_d;

  // Frame position advance; a restart on a fresh wrap keeps the bank
  function automatic ctr_t ctr_step(ctr_t c, logic restart,
                                    logic [1:0] last_ph, logic [8:0] nch);
    ctr_t n;
    n = c;
    if (restart) begin
      n = '0;
      n.bank = (c.ch == 8'h00 && c.bitn == 3'h0 && c.phase == 2'h0) ?
               c.bank : ~c.bank;
    end else if (c.phase == last_ph) begin
      n.phase = 2'h0;
      n.bitn  = 3'(c.bitn + 3'h1);
      if (c.bitn == 3'h7) begin
        if ({1'b0, c.ch} == 9'(nch - 9'h001)) begin
          n.ch   = 8'h00;
          n.bank = ~c.bank;
        end else begin
          n.ch = 8'(c.ch + 8'h01);
        end
      end
    end else begin
      n.phase = 2'(c.phase + 2'h1);
    end
    return n;
  endfunction : ctr_step

  // -----------------------------------------------------------------------
  // Combinational helpers shared with the checks
  // -----------------------------------------------------------------------
  logic       boundary;
  logic [1:0] last_ph;
  logic [8:0] nch;
  logic       host_sel;
  logic       host_take;
  logic       out_start;
  logic       in_end;
  logic       master_en;

  // Frame edge detection and divider settings
  always_comb begin
    if (wide_frame_select) begin
      boundary = s_q.fp_prev & ~frame_sync_pulse;
    end else begin
      boundary = (s_q.fp_prev == s_q.idle_lvl) &
                 (frame_sync_pulse != s_q.idle_lvl);
    end
    last_ph = (data_rate_select == RATE_16M) ? 2'(BIT_CLKS_FAST - 1) :
                                               2'(BIT_CLKS_SLOW - 1);
    nch = 9'(BASE_CHANNELS) << data_rate_select;
    host_sel  = ~host_req.cs_n & ~host_req.ds_n;
    host_take = host_sel & ~s_q.busy & (~host_req.rw | ~s_q.skid_v);
    out_start = (s_q.octr.phase == 2'h0);
    in_end    = (s_q.ictr.phase == last_ph);
    master_en = master_output_drive | output_standby;
  end

  // -----------------------------------------------------------------------
  // Next-state logic
  // -----------------------------------------------------------------------
  always_comb begin
    logic [3:0]  tap;
    logic        smp;
    cm_entry_t   e;
    logic        fresh;
    logic [7:0]  byte_v;
    logic [15:0] rword;
    logic [LANES-1:0] drive;
    tap    = 4'h0;
    smp    = 1'b0;
    e      = '0;
    fresh  = 1'b0;
    byte_v = 8'h00;
    rword  = 16'h0000;
    drive  = '0;
    s_d    = s_q;

    // Narrow pulse polarity learnt from the long idle level
    s_d.fp_prev = frame_sync_pulse;
    if (frame_sync_pulse != s_q.fp_prev) begin
      s_d.stable = 4'h0;
    end else if (s_q.stable == 4'(FP_IDLE_CLKS - 1)) begin
      s_d.idle_lvl = frame_sync_pulse;
    end else begin
      s_d.stable = 4'(s_q.stable + 4'h1);
    end

    s_d.octr = ctr_step(s_q.octr, boundary, last_ph, nch);
    // input side lags by the deepest offset
    s_d.bdly = {s_q.bdly[IN_DELAY_CLKS-2:0], boundary};
    s_d.ictr = ctr_step(s_q.ictr, s_q.bdly[IN_DELAY_CLKS-1], last_ph, nch);

    for (int l = 0; l < LANES; l++) begin
      s_d.hist[l] = {s_q.hist[l][14:0], serial_in_lanes[l]};
      // per-lane tap picks the lagged sample
      tap = 4'(MAX_OFF_HALVES) - lane_offset[l];
      smp = s_q.hist[l][tap];
      if (in_end) begin
        s_d.in_sr[l] = {s_q.in_sr[l][5:0], smp};
        // full byte into the bank being filled
        if (s_q.ictr.bitn == 3'h7) begin
          s_d.dm[s_q.ictr.bank][l][s_q.ictr.ch] = {s_q.in_sr[l], smp};
        end
      end

      e = s_q.cm[l][s_q.octr.ch];
      // Variable delay takes the newest stored copy of the source
      fresh = (e.src_chan < s_q.ictr.ch) ? s_q.ictr.bank : ~s_q.ictr.bank;
      case (e.mode)
        MODE_PROC: byte_v = e.src_chan;
        MODE_VAR: byte_v = s_q.dm[fresh][e.src_lane][e.src_chan];
        MODE_CONST: byte_v = s_q.dm[~s_q.ictr.bank][e.src_lane][e.src_chan];
        default: byte_v = 8'h00;
      endcase
      if (out_start) begin
        if (s_q.octr.bitn == 3'h0) begin
          s_d.chan_en[l] = (e.mode != MODE_OFF);
          s_d.out_bit[l] = byte_v[7];
          s_d.out_sr[l]  = {byte_v[6:0], 1'b0};
        end else begin
          // same divider as the input side
          s_d.out_bit[l] = s_q.out_sr[l][7];
          s_d.out_sr[l]  = {s_q.out_sr[l][6:0], 1'b0};
        end
      end
      drive[l] = master_en & s_d.chan_en[l];
    end

    // Output pins; the enable view drives actively
    s_d.low_q  = s_d.out_bit[HALF-1:0];
    s_d.low_oe = drive[HALF-1:0];
    if (all_lanes_select) begin
      s_d.high_q  = s_d.out_bit[LANES-1:HALF];
      s_d.high_oe = drive[LANES-1:HALF];
    end else begin
      s_d.high_q  = drive[HALF-1:0];
      s_d.high_oe = '1;
    end

    // Host access: one per strobe, reads stall while the buffer is full
    s_d.busy = host_sel & (s_q.busy | host_take);
    s_d.ack  = host_take & ~host_req.rw;
    if (host_req.addr[15:14] == ADDR_SEL_DM) begin
      rword = {8'h00,
               s_q.dm[~s_q.ictr.bank][host_req.addr[13:8]][host_req.addr[7:0]]};
    end else if (host_req.addr[15:14] == ADDR_SEL_CM) begin
      rword = s_q.cm[host_req.addr[13:8]][host_req.addr[7:0]];
    end
    if (host_take & ~host_req.rw &
        (host_req.addr[15:14] == ADDR_SEL_CM)) begin
      s_d.cm[host_req.addr[13:8]][host_req.addr[7:0]] = host_req.wdata;
    end

    // Two-entry read buffer: head drives the pins, skid absorbs a stall
    if (s_q.head_v & data_take) begin
      if (s_q.skid_v) begin
        s_d.head_d = s_q.skid_d;
        s_d.skid_v = host_take & host_req.rw;
        s_d.skid_d = rword;
      end else begin
        s_d.head_v = host_take & host_req.rw;
        s_d.head_d = rword;
      end
    end else if (host_take & host_req.rw) begin
      if (!s_q.head_v) begin
        s_d.head_v = 1'b1;
        s_d.head_d = rword;
      end else begin
        s_d.skid_v = 1'b1;
        s_d.skid_d = rword;
      end
    end
  end

  // -----------------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      s_q          <= '0;
      s_q.idle_lvl <= FP_IDLE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign data_out = s_q.head_d;
  assign data_oe  = s_q.head_v;
  assign ack      = s_q.ack;
  assign serial_out_lanes_low                 = s_q.low_q;
  assign serial_out_lanes_low_oe              = s_q.low_oe;
  assign serial_out_lanes_high_or_enable_view = s_q.high_q;
  assign serial_out_lanes_high_oe             = s_q.high_oe;

  // -----------------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence slow_bit;
    !out_start [*3] ##1 out_start;
  endsequence
  sequence fast_bit;
    !out_start ##1 out_start;
  endsequence

  a_master_off: assert property (
    !master_output_drive && !output_standby |=>
      serial_out_lanes_low_oe == '0 &&
      (serial_out_lanes_high_oe == '0 || !$past(all_lanes_select)))
    else $error("outputs driven while master enables are off");
  a_upper_view: assert property (
    !all_lanes_select |=> serial_out_lanes_high_or_enable_view ==
      serial_out_lanes_low_oe && serial_out_lanes_high_oe == '1)
    else $error("upper pins do not show lower lane enables");
  a_fast_bits: assert property (
    out_start && !boundary && data_rate_select == RATE_16M ##1
      $stable(data_rate_select) && !boundary |-> fast_bit)
    else $error("top rate bit is not two cycles");
  a_slow_bits: assert property (
    out_start && !boundary && data_rate_select != RATE_16M |->
      ##1 (slow_bit or ##[0:2] boundary))
    else $error("slow rate bit is not four cycles");
  a_frame_restart: assert property (
    boundary |=> s_q.octr.ch == 8'h00 && s_q.octr.bitn == 3'h0 &&
      s_q.octr.phase == 2'h0)
    else $error("output counters not restarted at frame edge");
  a_input_restart: assert property (
    boundary |-> ##17 s_q.ictr.ch == 8'h00 && s_q.ictr.bitn == 3'h0 &&
      s_q.ictr.phase == 2'h0)
    else $error("input counters not restarted after the lag");
  a_chan_off: assert property (
    out_start && s_q.octr.bitn == 3'h0 &&
      s_q.cm[0][s_q.octr.ch].mode == MODE_OFF |=>
      !serial_out_lanes_low_oe[0])
    else $error("disabled channel still driven");
  a_proc_byte: assert property (
    out_start && s_q.octr.bitn == 3'h0 &&
      s_q.cm[0][s_q.octr.ch].mode == MODE_PROC |=>
      serial_out_lanes_low[0] == $past(s_q.cm[0][s_q.octr.ch].src_chan[7]))
    else $error("processor byte not sent");
  a_host_write: assert property (
    host_take && !host_req.rw |=> ack ##1 !ack)
    else $error("write not acknowledged for one cycle");
  a_wide_edge: assert property (
    wide_frame_select && s_q.fp_prev && !frame_sync_pulse |-> boundary)
    else $error("wide pulse falling edge missed");

endmodule : tdm_time_slot_switch_core

// ==== verification/tdm_far_end.sv ====
// Far-end model: frame pulse source and 64 serial input lanes.
// Assumes a 40 MHz clk; drives its pins 1 ns after each rising edge.
`timescale 1ns/10ps
module tdm_far_end
  import tsi_pkg::*;
(
  input  wire logic             clk,       // System clock
  input  wire logic             reset,     // Sync, high
  input  wire rate_t            rate,      // Lane rate
  input  wire logic             pulse_inv, // High-going pulses
  input  wire logic [63:0][3:0] lag,       // Lag per lane, cycles
  output logic                  fp,        // Frame pulse
  output logic [63:0]           lanes,     // Serial lanes
  output int                    pos        // Cycle within frame
);
  // ---------------------------------------------------------------
  // Frame geometry and lane content
  // ---------------------------------------------------------------
  function automatic int frame_clks(input rate_t r);
    return (BASE_CHANNELS << r) * BYTE_BITS *
           ((r == RATE_16M) ? BIT_CLKS_FAST : BIT_CLKS_SLOW);
  endfunction : frame_clks

  // Same byte every frame, so both delay modes expect one value
  function automatic logic [7:0] pattern(input int lane, input int ch);
    return 8'(lane * 37 + ch * 11 + 90);
  endfunction : pattern

  initial begin
    pos   = 2;
    fp    = 1'b1;
    lanes = '0;
  end

  always @(posedge clk) begin : far_drive
    int         fc;
    int         bc;
    int         t;
    logic [7:0] by;
    #1;
    fc  = frame_clks(rate);
    bc  = (rate == RATE_16M) ? BIT_CLKS_FAST : BIT_CLKS_SLOW;
    pos = reset ? 2 : (pos + 1) % fc;
    fp  = (pos < 2) ^ !pulse_inv;
    // Bit window placed round the delayed input sampling point
    for (int l = 0; l < 64; l++) begin
      t        = ((pos + 2 * fc - 1 - int'(lag[l])) % fc) / bc;
      by       = pattern(l, t / BYTE_BITS);
      lanes[l] = by[7 - t % BYTE_BITS];
    end
  end
endmodule : tdm_far_end

// ==== verification/tdm_time_slot_switch_core_tb.sv ====
// Bench of the switch core: host port tasks, far-end lane model and a
// bit-slot model of every output lane. Assumes the far-end frame timing.
`timescale 1ns/10ps
module tdm_time_slot_switch_core_tb
  import tsi_pkg::*;
;
  logic             clk       = 1'b0;
  logic             reset     = 1'b1;
  logic             wide_sel  = 1'b0;
  logic             drive     = 1'b1;
  logic             standby   = 1'b0;
  logic             all_sel   = 1'b1;
  logic             take      = 1'b0;
  logic             pulse_inv = 1'b0;
  logic             chk_on    = 1'b0;
  rate_t            rate      = RATE_2M;
  logic [63:0][3:0] lag       = '0;
  host_req_t        req       = '{cs_n: 1'b1, ds_n: 1'b1, default: '0};
  logic             fp;
  logic [63:0]      lanes;
  logic [15:0]      dout;
  logic             doe;
  logic             ack;
  logic [31:0]      lo;
  logic [31:0]      lo_oe;
  logic [31:0]      hi;
  logic [31:0]      hi_oe;
  int               pos;
  int               fails     = 0;
  int               cmp_count = 0;
  cm_entry_t        cm_exp [64][256];

  always #12.5 clk = ~clk;

  tdm_time_slot_switch_core i_tdm_time_slot_switch_core (
    .clk(clk), .reset(reset), .serial_in_lanes(lanes),
    .frame_sync_pulse(fp), .wide_frame_select(wide_sel),
    .master_output_drive(drive), .output_standby(standby),
    .all_lanes_select(all_sel), .data_rate_select(rate),
    .lane_offset(lag), .host_req(req), .data_take(take),
    .data_out(dout), .data_oe(doe), .ack(ack),
    .serial_out_lanes_low(lo), .serial_out_lanes_low_oe(lo_oe),
    .serial_out_lanes_high_or_enable_view(hi),
    .serial_out_lanes_high_oe(hi_oe));

  tdm_far_end i_tdm_far_end (
    .clk(clk), .reset(reset), .rate(rate), .pulse_inv(pulse_inv),
    .lag(lag), .fp(fp), .lanes(lanes), .pos(pos));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic complete_run();
    if (fails == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run

  // Outputs must be quiet after sixteen cycles of reset
  task automatic do_reset();
    @(posedge clk);
    #1 reset = 1'b1;
    repeat (16) @(posedge clk);
    #1;
    check("reset_lanes", 32'h0, lo | lo_oe | hi | hi_oe);
    check("reset_host", 32'h0, {dout, doe, ack});
    reset  = 1'b0;
    cm_exp = '{default: '0};
  endtask : do_reset

  // Holds the strobe until the edge after ack shows
  task automatic host_write(input logic [15:0] a, input logic [15:0] d);
    int k;
    req = '{cs_n: 1'b0, ds_n: 1'b0, rw: 1'b0, addr: a, wdata: d};
    for (k = 0; k < 8 && ack !== 1'b1; k++) @(posedge clk) #1;
    check("write_ack", 32'h1, {31'h0, ack});
    if (a[15:14] == ADDR_SEL_CM) cm_exp[a[13:8]][a[7:0]] = cm_entry_t'(d);
    @(posedge clk) #1;
    req.cs_n = 1'b1;
    req.ds_n = 1'b1;
    @(posedge clk) #1;
  endtask : host_write

  // No answer when refused, so the strobe is held three edges
  task automatic host_read(input logic [15:0] a);
    req = '{cs_n: 1'b0, ds_n: 1'b0, rw: 1'b1, addr: a, wdata: 16'h0};
    repeat (3) @(posedge clk) #1;
    req.cs_n = 1'b1;
    req.ds_n = 1'b1;
    @(posedge clk) #1;
  endtask : host_read

  task automatic run_frames(input int skip);
    int fc;
    fc = i_tdm_far_end.frame_clks(rate);
    repeat (skip * fc) @(posedge clk);
    #1 chk_on = 1'b1;
    repeat (fc) @(posedge clk);
    #1 chk_on = 1'b0;
  endtask : run_frames

  // ---------------------------------------------------------------
  // Output lane model, checked once per bit slot
  // ---------------------------------------------------------------
  always @(posedge clk) begin : lane_model
    int          fc;
    int          bc;
    int          n;
    cm_entry_t   e;
    logic [7:0]  by;
    logic [63:0] oe_e;
    logic [63:0] bit_e;
    #2;
    fc = i_tdm_far_end.frame_clks(rate);
    bc = (rate == RATE_16M) ? BIT_CLKS_FAST : BIT_CLKS_SLOW;
    n  = (pos + fc - 2 - bc / 2) % fc; // Mid slot
    if (chk_on && n % bc == 0) begin
      n = n / bc;
      for (int l = 0; l < 64; l++) begin
        e  = cm_exp[l][n / BYTE_BITS];
        by = (e.mode == MODE_PROC) ? e.src_chan :
             i_tdm_far_end.pattern(int'(e.src_lane), int'(e.src_chan));
        oe_e[l]  = (drive | standby) & (e.mode != MODE_OFF);
        bit_e[l] = by[7 - n % BYTE_BITS];
      end
      check("low_oe", oe_e[31:0], lo_oe);
      check("low_bits", bit_e[31:0] & oe_e[31:0], lo & oe_e[31:0]);
      if (all_sel) begin
        check("high_oe", oe_e[63:32], hi_oe);
        check("high_bits", bit_e[63:32] & oe_e[63:32],
              hi & oe_e[63:32]);
      end else begin
        check("enable_view", oe_e[31:0], hi);
        check("view_oe", 32'hFFFFFFFF, hi_oe);
      end
    end
  end

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'hE06D));
    for (int l = 0; l < 64; l++) lag[l] = 4'($urandom % 16);
    do_reset();
    // Random entries across all four modes, then broadcast corners
    for (int k = 0; k < 24; k++) begin
      host_write({ADDR_SEL_CM, 6'($urandom), 8'($urandom % 32)},
                 {2'(k % 4), 6'($urandom),
                  (k % 4 == 2) ? 8'($urandom) : 8'($urandom % 32)});
    end
    host_write({ADDR_SEL_CM, 6'h00, 8'h05}, 16'h071F);
    host_write({ADDR_SEL_CM, 6'h3F, 8'h1F}, 16'h471F);
    host_write({ADDR_SEL_CM, 6'h00, 8'h02}, 16'hC000);
    host_write({ADDR_SEL_CM, 6'h00, 8'h03}, 16'h80A5);
    host_write(16'h4123, 16'hFFFF);
    host_write({ADDR_SEL_DM, 6'h07, 8'h1F}, 16'h00FF);
    run_frames(3);
    // Two reads fill the buffer, a third is refused, then drain
    host_read({ADDR_SEL_DM, 6'h07, 8'h1F});
    host_read({ADDR_SEL_CM, 6'h00, 8'h05});
    host_read(16'h4000);
    take = 1'b1;
    check("read_dm", {16'h0001, 8'h00, i_tdm_far_end.pattern(7, 31)},
          {doe, dout});
    @(posedge clk) #1;
    check("read_cm", 32'h1071F, {doe, dout});
    @(posedge clk) #1;
    take = 1'b0;
    check("read_empty", 32'h0, {31'h0, doe});
    host_read(16'h4000);
    check("read_unmapped", 32'h10000, {doe, dout});
    take = 1'b1;
    @(posedge clk) #1;
    take = 1'b0;
    // Master drive and standby combinations, enable view on upper pins
    all_sel = 1'b0;
    for (int m = 0; m < 3; m++) begin
      drive   = m[1];
      standby = m[0];
      run_frames(1);
    end
    drive   = 1'b1;
    standby = 1'b0;
    all_sel = 1'b1;
    // Remaining rates, last channel of the last lane in processor mode
    for (int r = 1; r < 4; r++) begin
      // Rate only moves under reset, so no bit is cut short
      @(posedge clk);
      #1 reset = 1'b1;
      rate      = rate_t'(r);
      wide_sel  = (r == 2);
      pulse_inv = (r == 1);
      do_reset();
      host_write({ADDR_SEL_CM, 6'h3F, 8'((32 << r) - 1)},
                 {MODE_PROC, 6'h00, 8'($urandom)});
      run_frames(3);
    end
    complete_run();
  end

  // Longest expected run is near 50000 cycles
  initial begin
    #(80000 * 25);
    check("watchdog", 32'h0, 32'h1);
    complete_run();
  end
endmodule : tdm_time_slot_switch_core_tb
